// ---- hdl/swb_pkg.sv ----
// Shared constants for the serial wakeup, break and status block.
// Assumes a 32-bit APB host with an 8-bit byte address.
package swb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CFG  = 8'h0C;
  localparam logic [7:0] OFS_IST  = 8'h10;
  localparam logic [7:0] OFS_IMSK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_TXON   = 3;
  localparam int CTL_STBY   = 1;
  localparam int CTL_BRK    = 0;
  localparam int ST_TX_BUFFER_EMPTY    = 7;
  localparam int ST_TC      = 6;
  localparam int ST_RX_BUFFER_FULL    = 5;
  localparam int CFG_WAKE   = 0;
  localparam int CFG_NINE   = 1;
  localparam int CFG_TXB8   = 2;
  localparam int IRQ_TX_BUFFER_EMPTY   = 0;
  localparam int IRQ_TC     = 1;
  localparam int IRQ_RX_BUFFER_FULL   = 2;
  localparam int IRQ_WAKE   = 3;
  localparam int IRQ_W      = 4;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] CFG_RST  = 3'h0;
  localparam int         BIT_CYC  = 16;
  localparam int         FRM_SHORT = 10;
  localparam int         FRM_LONG  = 11;

  typedef enum logic {TX_IDLE, TX_SHIFT} swb_tx_e;

endpackage : swb_pkg

// ---- hdl/swb_core.sv ----
// Serial receiver standby/wakeup, break queuing and first status flags.
// Assumes an external receive shifter that pulses rx_char_valid and
// rx_idle_line; the transmit shifter and bit timer are held here.
`timescale 1ns/100ps
`default_nettype none
module swb_core
  import swb_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Receive shifter side
  input  wire logic        rx_char_valid,
  input  wire logic [8:0]  rx_char,
  input  wire logic        rx_idle_line,
  // Serial transmit pin
  output var  logic        tx_out,
  output var  logic        tx_oe,
  // Interrupt
  output var  logic        irq
);

  // Bit timer is 16 bits wide; zero would wrap the bit end count to 16'hFFFF, a 65536-cycle bit
  if (BIT_CYCLES < 1 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic acc     = ce & psel & penable;
  wire logic wr      = acc & pwrite;
  wire logic rd      = acc & ~pwrite;
  wire logic hit_ctl = (paddr == OFS_CTRL);
  wire logic hit_st  = (paddr == OFS_STAT);
  wire logic hit_dat = (paddr == OFS_DATA);
  wire logic hit_cfg = (paddr == OFS_CFG);
  wire logic hit_ist = (paddr == OFS_IST);
  wire logic hit_msk = (paddr == OFS_IMSK);
  wire logic mapped  = hit_ctl | hit_st | hit_dat | hit_cfg | hit_ist | hit_msk;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic            txon_q, stby_q, brk_q;
  logic [2:0]      cfg_q;
  logic            tx_buffer_empty_q, tc_q, rx_buffer_full_q;
  logic            arm_tx_buffer_empty_q, arm_tc_q, arm_rx_buffer_full_q;
  logic [7:0]      txbuf_q, rxbuf_q;
  logic            pre_pend_q, brk_pend_q;
  swb_tx_e         tx_st_q;
  logic [10:0]     sh_q;
  logic [3:0]      nbit_q;
  logic [15:0]     tim_q;
  logic [IRQ_W-1:0] ist_q, msk_q;
  logic [31:0]     prdata_q;

  wire logic       nine     = cfg_q[CFG_NINE];
  wire logic [3:0] frm_len  = nine ? 4'(FRM_LONG) : 4'(FRM_SHORT);
  wire logic       wr_ctl   = wr & hit_ctl;
  wire logic       wr_dat   = wr & hit_dat;
  wire logic       rd_dat   = rd & hit_dat;
  wire logic       rd_st    = rd & hit_st;
  wire logic       te_rise  = wr_ctl & pwdata[CTL_TXON] & ~txon_q;
  wire logic       brk_wr1  = wr_ctl & pwdata[CTL_BRK];

  // ----------------------------------------------------------------
  // Receiver standby and wakeup
  // ----------------------------------------------------------------
  wire logic msb     = nine ? rx_char[8] : rx_char[7];
  wire logic wake_ev = stby_q & (cfg_q[CFG_WAKE]
                         ? (rx_char_valid & msb)
                         : rx_idle_line);
  // Standby discards characters; the address mark that wakes is kept
  wire logic rx_take = rx_char_valid & ~rx_buffer_full_q & (~stby_q | wake_ev);
  wire logic stby_d  = wr_ctl ? pwdata[CTL_STBY]
                              : (stby_q & ~wake_ev);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  wire logic tx_busy  = (tx_st_q == TX_SHIFT);
  wire logic bit_end  = tx_busy & (tim_q == 16'(BIT_CYCLES - 1));
  wire logic frm_end  = bit_end & (nbit_q == frm_len - 4'd1);
  wire logic tx_free  = ~tx_busy | frm_end;
  wire logic pre_pend = pre_pend_q | te_rise;
  // A held break bit keeps the queue full so back-to-back breaks follow
  wire logic brk_pend = brk_pend_q | brk_wr1 | brk_q;
  wire logic go_pre   = txon_q & tx_free & pre_pend;
  wire logic go_brk   = txon_q & tx_free & ~pre_pend & brk_pend;
  wire logic go_dat   = txon_q & tx_free & ~pre_pend & ~brk_pend & ~tx_buffer_empty_q;
  wire logic go_any   = go_pre | go_brk | go_dat;
  wire logic [10:0] dat_frm = {1'b1, nine ? cfg_q[CFG_TXB8] : 1'b1, txbuf_q, 1'b0};
  wire logic [10:0] ld_frm  = go_pre ? 11'h7FF : (go_brk ? 11'h000 : dat_frm);

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Set wins over the clear sequence for every flag
  wire logic tx_buffer_empty_clr = arm_tx_buffer_empty_q & wr_dat;
  wire logic tx_buffer_empty_d   = go_dat | (tx_buffer_empty_q & ~tx_buffer_empty_clr);
  wire logic tc_clr   = arm_tc_q & (wr_dat | te_rise | brk_wr1);
  wire logic busy_d   = go_any | (tx_busy & ~frm_end);
  wire logic brk_q_d  = wr_ctl ? pwdata[CTL_BRK] : brk_q;
  wire logic tc_set   = tx_buffer_empty_d & ~busy_d & ~(pre_pend & ~go_pre)
                        & ~brk_q_d & ~((brk_pend_q | brk_wr1) & ~go_brk);
  wire logic tc_d     = tc_set | (tc_q & ~tc_clr);
  wire logic rx_buffer_full_clr = arm_rx_buffer_full_q & rd_dat;
  wire logic rx_buffer_full_d   = rx_take | (rx_buffer_full_q & ~rx_buffer_full_clr);
  wire logic [7:0] stat = {tx_buffer_empty_q, tc_q, rx_buffer_full_q, 5'h00};

  wire logic [IRQ_W-1:0] ev = {wake_ev, rx_take, tc_set & ~tc_q, go_dat};
  wire logic [IRQ_W-1:0] ist_d = ev | (ist_q & ~((wr & hit_ist) ? pwdata[IRQ_W-1:0] : '0));

  wire logic [31:0] rd_mux =
      hit_ctl ? {28'h0000_000, txon_q, 1'b0, stby_q, brk_q} :
      hit_st  ? {24'h00_0000, stat} :
      hit_dat ? {24'h00_0000, rxbuf_q} :
      hit_cfg ? {29'h000_0000, cfg_q} :
      hit_ist ? {28'h0000_000, ist_q} :
      hit_msk ? {28'h0000_000, msk_q} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txon_q <= CTRL_RST[CTL_TXON];
      stby_q <= CTRL_RST[CTL_STBY];
      brk_q  <= CTRL_RST[CTL_BRK];
      cfg_q  <= CFG_RST;
      msk_q  <= '0;
      ist_q  <= '0;
    end else if (ce) begin
      if (wr_ctl) begin
        txon_q <= pwdata[CTL_TXON];
        brk_q  <= pwdata[CTL_BRK];
      end
      stby_q <= stby_d;
      if (wr & hit_cfg) begin
        cfg_q <= pwdata[2:0];
      end
      if (wr & hit_msk) begin
        msk_q <= pwdata[IRQ_W-1:0];
      end
      ist_q <= ist_d;
    end
  end

  // Status register takes no write path at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty_q     <= 1'b1;
      tc_q       <= 1'b1;
      rx_buffer_full_q     <= 1'b0;
      arm_tx_buffer_empty_q <= 1'b0;
      arm_tc_q   <= 1'b0;
      arm_rx_buffer_full_q <= 1'b0;
    end else if (ce) begin
      tx_buffer_empty_q     <= tx_buffer_empty_d;
      tc_q       <= tc_d;
      rx_buffer_full_q     <= rx_buffer_full_d;
      arm_tx_buffer_empty_q <= tx_buffer_empty_d & ((rd_st & prdata_q[ST_TX_BUFFER_EMPTY]) | (arm_tx_buffer_empty_q & ~tx_buffer_empty_clr));
      arm_tc_q   <= tc_d & ((rd_st & prdata_q[ST_TC]) | (arm_tc_q & ~tc_clr));
      arm_rx_buffer_full_q <= rx_buffer_full_d & ((rd_st & prdata_q[ST_RX_BUFFER_FULL]) | (arm_rx_buffer_full_q & ~rx_buffer_full_clr));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf_q <= 8'h00;
      rxbuf_q <= 8'h00;
    end else if (ce) begin
      if (wr_dat) begin
        txbuf_q <= pwdata[7:0];
      end
      if (rx_take) begin
        rxbuf_q <= rx_char[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else if (ce) begin
      pre_pend_q <= pre_pend & ~go_pre;
      brk_pend_q <= (brk_pend_q | brk_wr1) & ~go_brk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      sh_q    <= 11'h7FF;
      nbit_q  <= 4'd0;
      tim_q   <= 16'h0000;
    end else if (ce) begin
      case (tx_st_q)
        TX_IDLE: begin
          if (go_any) begin
            tx_st_q <= TX_SHIFT;
            sh_q    <= ld_frm;
            nbit_q  <= 4'd0;
            tim_q   <= 16'h0000;
          end
        end
        TX_SHIFT: begin
          if (frm_end && go_any) begin
            sh_q   <= ld_frm;
            nbit_q <= 4'd0;
            tim_q  <= 16'h0000;
          end else if (frm_end) begin
            tx_st_q <= TX_IDLE;
            sh_q    <= 11'h7FF;
          end else if (bit_end) begin
            sh_q   <= {1'b1, sh_q[10:1]};
            nbit_q <= nbit_q + 4'd1;
            tim_q  <= 16'h0000;
          end else begin
            tim_q <= tim_q + 16'h0001;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign tx_out = tx_busy ? sh_q[0] : 1'b1;
  // Pin stays driven until a frame in flight ends after disable
  assign tx_oe  = txon_q | tx_busy;
  assign irq    = |(ist_q & msk_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_brk_start;
    ce && go_brk;
  endsequence
  // Shortest break is ten one-cycle bits, so eight cycles always fit
  sequence s_brk_low;
    (!tx_out && tx_oe) [*8];
  endsequence

  property p_stby_set;
    ce && wr_ctl && pwdata[CTL_STBY] |=> stby_q;
  endproperty
  a_stby_set: assert property (p_stby_set) else $error("standby not entered");
  property p_wake_idle;
    ce && stby_q && !cfg_q[CFG_WAKE] && rx_idle_line && !wr_ctl |=> !stby_q;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("idle wake missed");
  property p_stay_stby;
    ce && stby_q && cfg_q[CFG_WAKE] && !rx_idle_line && !(rx_char_valid && msb) && !wr_ctl
      |=> stby_q && !rx_buffer_full_q || $past(rx_buffer_full_q);
  endproperty
  a_stay_stby: assert property (p_stay_stby) else $error("standby left early");
  property p_stby_off;
    ce && wr_ctl && !pwdata[CTL_STBY] |=> !stby_q;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby not cleared");
  property p_brk_low;
    s_brk_start |=> s_brk_low;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low");
  property p_tx_buffer_empty_load;
    ce && go_dat |=> tx_buffer_empty_q && tx_busy && !tx_out;
  endproperty
  a_tx_buffer_empty_load: assert property (p_tx_buffer_empty_load) else $error("load wrong");
  property p_tx_buffer_empty_noarm;
    ce && tx_buffer_empty_q && !arm_tx_buffer_empty_q && wr_dat |=> tx_buffer_empty_q;
  endproperty
  a_tx_buffer_empty_noarm: assert property (p_tx_buffer_empty_noarm) else $error("unarmed clear");
  property p_tx_buffer_empty_clr;
    ce && tx_buffer_empty_clr && !go_dat |=> !tx_buffer_empty_q;
  endproperty
  a_tx_buffer_empty_clr: assert property (p_tx_buffer_empty_clr) else $error("tx_buffer_empty not cleared");
  property p_tc_idle;
    ce && !wr && tx_buffer_empty_q && !tx_busy && !pre_pend_q && !brk_pend_q && !brk_q |=> tc_q;
  endproperty
  a_tc_idle: assert property (p_tc_idle) else $error("tc not set when idle");
  property p_tc_clr;
    tc_clr && !tc_set |=> !tc_q;
  endproperty
  a_tc_clr: assert property (p_tc_clr) else $error("tc not cleared");
  property p_rx_buffer_full_set;
    ce && rx_take |=> rx_buffer_full_q && rxbuf_q == 8'($past(rx_char));
  endproperty
  a_rx_buffer_full_set: assert property (p_rx_buffer_full_set) else $error("rx_buffer_full not set");
  property p_rx_buffer_full_clr;
    rx_buffer_full_clr && !rx_take |=> !rx_buffer_full_q;
  endproperty
  a_rx_buffer_full_clr: assert property (p_rx_buffer_full_clr) else $error("rx_buffer_full not cleared");
  property p_pre_q;
    ce && te_rise |=> pre_pend_q || tx_busy;
  endproperty
  a_pre_q: assert property (p_pre_q) else $error("preamble lost");

endmodule : swb_core
`default_nettype wire

// ---- tb/swb_peer.sv ----
// Remote serial peer: hands received characters and idle pulses to
// the block and times every low run seen on the transmit pin.
// Assumes the same clock as the block; one character per call.
`timescale 1ns/100ps
`default_nettype none
module swb_peer (
  // Clock
  input  wire logic       pclk,
  // Transmit pin
  input  wire logic       tx_out,
  input  wire logic       tx_oe,
  // Receive shifter side
  output var  logic       rx_char_valid,
  output var  logic [8:0] rx_char,
  output var  logic       rx_idle_line,
  // Low run timing
  output var  int         low_run,
  output var  int         n_runs
);
  int cnt;

  initial begin
    rx_char_valid = 1'b0;
    rx_char       = 9'h0AA;
    rx_idle_line  = 1'b0;
    low_run       = 0;
    n_runs        = 0;
    cnt           = 0;
  end

  // Pin only counts while the block drives it
  always @(posedge pclk) begin
    if (tx_oe === 1'b1 && tx_out === 1'b0) begin
      cnt++;
    end else if (cnt > 0) begin
      low_run = cnt;
      n_runs++;
      cnt = 0;
    end
  end

  task automatic send_char(input logic [8:0] c);
    @(posedge pclk);
    rx_char       <= c;
    rx_char_valid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    // Stale data must not look valid
    rx_char       <= ~c;
  endtask : send_char

  task automatic send_idle;
    @(posedge pclk);
    rx_idle_line <= 1'b1;
    @(posedge pclk);
    rx_idle_line <= 1'b0;
  endtask : send_idle
endmodule : swb_peer
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the wakeup, break and status block.
// Assumes zero-wait APB and a short bit time for quick frames.
`timescale 1ns/100ps
`default_nettype none
module tb
  import swb_pkg::*;
;
  localparam int BC = 2;
  logic       pclk = 1'b0;
  logic       presetn = 1'b0;
  logic       psel = 1'b0;
  logic       penable = 1'b0;
  logic       pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic       pready, pslverr, tx_out, tx_oe, irq;
  logic       rx_char_valid, rx_idle_line;
  logic [8:0] rx_char;
  logic [7:0] v;
  logic       err;
  int         failures = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         n0;
  int         low_run, n_runs;
  logic       ce = 1'b1;

  always #20 pclk = ~pclk;

  swb_core #(.BIT_CYCLES(BC)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_idle_line(rx_idle_line), .tx_out(tx_out), .tx_oe(tx_oe), .irq(irq)
  );

  swb_peer u_peer (
    .pclk(pclk), .tx_out(tx_out), .tx_oe(tx_oe),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_idle_line(rx_idle_line), .low_run(low_run), .n_runs(n_runs)
  );

  task automatic finish_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v       = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
    apb(1'b0, a, 8'h00);
    chk(v, e, m);
  endtask : rdchk

  task automatic wait_run(input int k);
    for (int i = 0; i < 400 && n_runs == k; i++) @(posedge pclk);
  endtask : wait_run

  task automatic t_reset;
    rdchk(OFS_STAT, 8'hC0, "status reset");
    rdchk(OFS_CTRL, 8'h00, "control reset");
    wr(OFS_STAT, 8'h00);
    rdchk(OFS_STAT, 8'hC0, "status write");
    apb(1'b0, 8'h3C, 8'h00);
    chk({7'h00, err}, 8'h01, "unmapped");
    chk({7'h00, tx_oe}, 8'h00, "pin off");
  endtask : t_reset

  task automatic t_tx;
    wr(OFS_CTRL, 8'h08);
    // Enable lands at the access edge; look at the pin once it has settled
    @(posedge pclk);
    chk({7'h00, tx_oe}, 8'h01, "pin on");
    rdchk(OFS_STAT, 8'h80, "preamble busy");
    repeat (30) @(posedge pclk);
    rdchk(OFS_STAT, 8'hC0, "idle again");
    n0 = n_runs;
    wr(OFS_DATA, 8'h0F);
    rdchk(OFS_STAT, 8'h80, "frame busy");
    repeat (30) @(posedge pclk);
    // Low nibble first, so the last low run is four bits long
    chk(8'(low_run), 8'(4 * BC), "lsb first");
    // Start bit and the high nibble are the only low runs
    chk(8'(n_runs - n0), 8'h02, "two low runs");
    rdchk(OFS_STAT, 8'hC0, "frame done");
    rdchk(OFS_IST, 8'h03, "tx events");
    wr(OFS_IST, 8'h0F);
    rdchk(OFS_IST, 8'h00, "events cleared");
  endtask : t_tx

  task automatic t_rx;
    wr(OFS_IMSK, 8'h04);
    u_peer.send_char(9'h041);
    rdchk(OFS_DATA, 8'h41, "data unarmed");
    chk({7'h00, irq}, 8'h01, "irq high");
    rdchk(OFS_STAT, 8'hE0, "full kept");
    rdchk(OFS_DATA, 8'h41, "data armed");
    rdchk(OFS_STAT, 8'hC0, "full cleared");
    wr(OFS_IST, 8'h04);
    rdchk(OFS_IST, 8'h00, "irq w1c");
    chk({7'h00, irq}, 8'h00, "irq low");
  endtask : t_rx

  task automatic t_wake;
    wr(OFS_CFG, 8'h00);
    wr(OFS_CTRL, 8'h0A);
    rdchk(OFS_CTRL, 8'h0A, "standby");
    u_peer.send_char(9'h033);
    rdchk(OFS_STAT, 8'hC0, "dropped");
    u_peer.send_idle;
    rdchk(OFS_CTRL, 8'h08, "idle wake");
    wr(OFS_CFG, 8'h01);
    wr(OFS_CTRL, 8'h0A);
    u_peer.send_idle;
    u_peer.send_char(9'h011);
    rdchk(OFS_CTRL, 8'h0A, "no mark");
    u_peer.send_char(9'h081);
    rdchk(OFS_CTRL, 8'h08, "mark wake");
    rdchk(OFS_STAT, 8'hE0, "mark kept");
    rdchk(OFS_DATA, 8'h81, "mark data");
    wr(OFS_CTRL, 8'h0A);
    wr(OFS_CTRL, 8'h08);
    rdchk(OFS_CTRL, 8'h08, "sw exit");
    u_peer.send_char(9'h022);
    rdchk(OFS_STAT, 8'hE0, "normal rx");
    rdchk(OFS_DATA, 8'h22, "normal data");
    rdchk(OFS_IST, 8'h0C, "wake events");
    wr(OFS_IST, 8'h0F);
  endtask : t_wake

  task automatic t_break;
    n0 = n_runs;
    wr(OFS_CTRL, 8'h09);
    rdchk(OFS_STAT, 8'h80, "break busy");
    wr(OFS_CTRL, 8'h08);
    wait_run(n0);
    chk(8'(low_run), 8'(FRM_SHORT * BC), "one break");
    wr(OFS_CFG, 8'h02);
    n0 = n_runs;
    wr(OFS_CTRL, 8'h09);
    // Held well past one break so several go back to back
    repeat (50) @(posedge pclk);
    wr(OFS_CTRL, 8'h08);
    wait_run(n0);
    chk({7'h00, (low_run % (FRM_LONG * BC) == 0)
        && (low_run >= 2 * FRM_LONG * BC)}, 8'h01, "held break");
    rdchk(OFS_STAT, 8'hC0, "break done");
  endtask : t_break

  // A character offered while the enable is low must leave no trace
  task automatic t_freeze;
    ce <= 1'b0;
    u_peer.send_char(9'h055);
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    rdchk(OFS_STAT, 8'hC0, "frozen rx");
    rdchk(OFS_DATA, 8'h22, "frozen data");
  endtask : t_freeze

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_wake;
    t_break;
    t_freeze;
    finish_test;
  end
endmodule : tb
`default_nettype wire
